// *** design/ptimer_pkg.sv ***
// package: register map, field positions, reset values, modes
package ptimer_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_MODE_CTRL = 5'h00;
	localparam logic [4:0] ADDR_RUN_CTRL = 5'h04;
	localparam logic [4:0] ADDR_COUNT_LOW = 5'h08;
	localparam logic [4:0] ADDR_COUNT_HIGH = 5'h0c;
	localparam logic [4:0] ADDR_DUTY_LOW = 5'h10;
	localparam logic [4:0] ADDR_DUTY_HIGH = 5'h14;
	localparam logic [4:0] ADDR_PERIOD_LOW = 5'h18;
	localparam logic [4:0] ADDR_PERIOD_HIGH = 5'h1c;
	// address width of the slave
	localparam int ADDR_W = 5;
	// timer_mode_ctrl fields
	localparam int MODE_POS = 6;
	localparam int PINF_POS = 4;
	localparam int INIT_POS = 3;
	localparam int INV_POS = 2;
	localparam int CLR_POS = 0;
	// timer_run_ctrl fields (also holds the match flags)
	localparam int PAUSE_POS = 7;
	localparam int CKSEL_POS = 4;
	localparam int ON_POS = 3;
	localparam int PFLAG_POS = 1;
	localparam int AFLAG_POS = 0;
	// reset values and counter maximum
	localparam logic [7:0] MODE_CTRL_RST = 8'h00;
	localparam logic [7:0] RUN_CTRL_RST = 8'h00;
	localparam logic [9:0] VALUE_RST = 10'h000;
	localparam logic [9:0] COUNT_MAX = 10'h3ff;
	// internal prescaler divide counts
	localparam logic [5:0] DIV_SYS4 = 6'h03;
	localparam logic [5:0] DIV_H16 = 6'h0f;
	localparam logic [5:0] DIV_H64 = 6'h3f;
	localparam logic [5:0] DIV_SUB = 6'h1f;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// operating modes
	typedef enum logic [1:0]
	{
		MODE_COMPARE = 2'b00,
		MODE_UNDEF = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TIMER = 2'b11
	} op_mode_e;
	// clock sources
	typedef enum logic [2:0]
	{
		CK_SYS4 = 3'b000,
		CK_SYS = 3'b001,
		CK_H16 = 3'b010,
		CK_H64 = 3'b011,
		CK_SUB0 = 3'b100,
		CK_SUB1 = 3'b101,
		CK_EXT_RISE = 3'b110,
		CK_EXT_FALL = 3'b111
	} clock_sel_e;
endpackage

// *** design/ext_clock_sync.sv ***
// three-stage synchroniser with edge detection for the external clock pin
`timescale 1ns/1ps
module ext_clock_sync
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pin in, edges out
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;

	// shift chain; first stage feeds only the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// accepted level changes only when stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lvl_r <= 1'b0;
		else if (s2_r == s3_r)
			lvl_r <= s3_r;
	end

	assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
	assign fall = (s2_r == s3_r) && !s3_r && lvl_r;
endmodule

// *** design/periodic_timer.sv ***
// periodic timer with compare output, axi4-lite register slave
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module periodic_timer
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic ext_clock_pin,
	output logic timer_output_pin
);
	logic [7:0] mode_ctrl_r;
	logic [7:0] run_ctrl_r;
	logic [9:0] duty_compare_value;
	logic [9:0] period_value_bits;
	logic [9:0] count_r;
	logic duty_match_flag;
	logic period_match_flag;
	logic raw_out_r;
	logic on_d_r;
	logic [5:0] pre_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [4:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic ext_rise;
	logic ext_fall;

	// field views
	ptimer_pkg::op_mode_e op_mode_sel;
	ptimer_pkg::clock_sel_e clock_source_sel;
	logic [1:0] pin_function_sel;
	logic output_init_level;
	logic output_invert;
	logic clear_source_sel;
	logic counter_on;
	logic counter_pause;
	assign op_mode_sel = ptimer_pkg::op_mode_e'(
		mode_ctrl_r[ptimer_pkg::MODE_POS +: 2]);
	assign pin_function_sel = mode_ctrl_r[ptimer_pkg::PINF_POS +: 2];
	assign output_init_level = mode_ctrl_r[ptimer_pkg::INIT_POS];
	assign output_invert = mode_ctrl_r[ptimer_pkg::INV_POS];
	assign clear_source_sel = mode_ctrl_r[ptimer_pkg::CLR_POS];
	assign clock_source_sel = ptimer_pkg::clock_sel_e'(
		run_ctrl_r[ptimer_pkg::CKSEL_POS +: 3]);
	assign counter_on = run_ctrl_r[ptimer_pkg::ON_POS];
	assign counter_pause = run_ctrl_r[ptimer_pkg::PAUSE_POS];
	assign duty_match_flag = run_ctrl_r[ptimer_pkg::AFLAG_POS];
	assign period_match_flag = run_ctrl_r[ptimer_pkg::PFLAG_POS];

	ext_clock_sync u_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(ext_clock_pin),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	////////////////////////////////////////////////////////////////////
	// counter clock tick selection
	logic [5:0] div_lim;
	logic tick;
	logic on_rise;
	always_comb
	begin
		div_lim = ptimer_pkg::DIV_SYS4;
		tick = 1'b0;
		unique case (clock_source_sel)
			ptimer_pkg::CK_SYS4: div_lim = ptimer_pkg::DIV_SYS4;
			ptimer_pkg::CK_SYS: div_lim = 6'h00;
			ptimer_pkg::CK_H16: div_lim = ptimer_pkg::DIV_H16;
			ptimer_pkg::CK_H64: div_lim = ptimer_pkg::DIV_H64;
			ptimer_pkg::CK_SUB0: div_lim = ptimer_pkg::DIV_SUB;
			ptimer_pkg::CK_SUB1: div_lim = ptimer_pkg::DIV_SUB;
			ptimer_pkg::CK_EXT_RISE: div_lim = 6'h00;
			ptimer_pkg::CK_EXT_FALL: div_lim = 6'h00;
		endcase
		if (clock_source_sel == ptimer_pkg::CK_EXT_RISE)
			tick = ext_rise;
		else if (clock_source_sel == ptimer_pkg::CK_EXT_FALL)
			tick = ext_fall;
		else
			tick = (pre_r >= div_lim);
	end
	assign on_rise = counter_on && !on_d_r;

	// prescaler for internal sources
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_r <= 6'h00;
		else if (!counter_on || pre_r >= div_lim)
			pre_r <= 6'h00;
		else
			pre_r <= pre_r + 6'h01;
	end

	// counter_on delay for edge detect
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			on_d_r <= 1'b0;
		else
			on_d_r <= counter_on;
	end

	////////////////////////////////////////////////////////////////////
	// compare and clear decisions
	logic running;
	logic pwm_mode;
	logic a_match;
	logic p_match;
	logic ovf;
	logic do_clear;
	logic set_a;
	logic set_p;
	logic pulse_end;
	assign running = counter_on && !on_rise && !counter_pause && tick;
	assign pwm_mode = (op_mode_sel == ptimer_pkg::MODE_PWM);
	// zero duty never matches
	assign a_match = running && (duty_compare_value != 10'h000)
		&& (count_r == duty_compare_value);
	assign p_match = running && (period_value_bits != 10'h000)
		&& (count_r == period_value_bits);
	assign ovf = running && (count_r == ptimer_pkg::COUNT_MAX);
	always_comb
	begin
		do_clear = 1'b0;
		set_a = a_match;
		set_p = p_match;
		if (pwm_mode)
			do_clear = p_match || (period_value_bits == 10'h000 && ovf);
		else if (clear_source_sel)
		begin
			do_clear = a_match;
			set_p = 1'b0;
		end
		else
			do_clear = p_match || (period_value_bits == 10'h000 && ovf);
	end
	assign pulse_end = pwm_mode && (pin_function_sel == 2'b11) && a_match;

	// counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_r <= ptimer_pkg::VALUE_RST;
		else if (on_rise)
			count_r <= 10'h000;
		else if (do_clear || pulse_end)
			count_r <= 10'h000;
		else if (running)
			count_r <= count_r + 10'h001;
	end

	////////////////////////////////////////////////////////////////////
	// raw output level before polarity
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			raw_out_r <= 1'b0;
		else if (on_rise)
			raw_out_r <= output_init_level;
		else if (op_mode_sel == ptimer_pkg::MODE_COMPARE && a_match)
		begin
			// only A match moves the pin
			unique case (pin_function_sel)
				2'b00: raw_out_r <= raw_out_r;
				2'b01: raw_out_r <= 1'b0;
				2'b10: raw_out_r <= 1'b1;
				2'b11: raw_out_r <= !raw_out_r;
			endcase
		end
		else if (pwm_mode)
		begin
			unique case (pin_function_sel)
				2'b00: raw_out_r <= !output_init_level;
				2'b01: raw_out_r <= output_init_level;
				2'b10: raw_out_r <= (count_r < duty_compare_value)
					? output_init_level : !output_init_level;
				2'b11: raw_out_r <= counter_on
					? output_init_level : !output_init_level;
			endcase
		end
	end

	// pin with inversion; timer mode holds pin low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_output_pin <= 1'b0;
		else if (op_mode_sel == ptimer_pkg::MODE_TIMER)
			timer_output_pin <= 1'b0;
		else
			timer_output_pin <= raw_out_r ^ output_invert;
	end

	////////////////////////////////////////////////////////////////////
	// axi write channel capture
	logic wr_go;
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 5'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_hold_r)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_hold_r <= 1'b0;
			if (s_axi_wvalid && !w_hold_r)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_go)
				w_hold_r <= 1'b0;
			// ready registered as the inverse of the next hold state
			s_axi_awready <= !(s_axi_awvalid && !aw_hold_r)
				&& !(aw_hold_r && !wr_go);
			s_axi_wready <= !(s_axi_wvalid && !w_hold_r)
				&& !(w_hold_r && !wr_go);
		end
	end

	// write response
	logic wr_hit;
	assign wr_hit = (awaddr_r[1:0] == 2'b00);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ptimer_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? ptimer_pkg::RESP_OKAY
				: ptimer_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// register writes; byte lane 0 only
	logic wr_b0;
	assign wr_b0 = wr_go && wr_hit && wstrb_r[0];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_ctrl_r <= ptimer_pkg::MODE_CTRL_RST;
			duty_compare_value <= ptimer_pkg::VALUE_RST;
			period_value_bits <= ptimer_pkg::VALUE_RST;
		end
		else if (wr_b0)
		begin
			unique case (awaddr_r)
				ptimer_pkg::ADDR_MODE_CTRL: mode_ctrl_r <= wdata_r[7:0];
				ptimer_pkg::ADDR_DUTY_LOW:
					duty_compare_value[7:0] <= wdata_r[7:0];
				ptimer_pkg::ADDR_DUTY_HIGH:
					duty_compare_value[9:8] <= wdata_r[1:0];
				ptimer_pkg::ADDR_PERIOD_LOW:
					period_value_bits[7:0] <= wdata_r[7:0];
				ptimer_pkg::ADDR_PERIOD_HIGH:
					period_value_bits[9:8] <= wdata_r[1:0];
				default: ;
			endcase
		end
	end

	// run control and sticky flags; set beats clear
	logic wr_run;
	assign wr_run = wr_b0 && (awaddr_r == ptimer_pkg::ADDR_RUN_CTRL);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			run_ctrl_r <= ptimer_pkg::RUN_CTRL_RST;
		else
		begin
			if (wr_run)
				run_ctrl_r[7:3] <= wdata_r[7:3];
			else if (pulse_end)
				run_ctrl_r[ptimer_pkg::ON_POS] <= 1'b0;
			else if (pwm_mode && pin_function_sel == 2'b11
				&& ext_rise)
				run_ctrl_r[ptimer_pkg::ON_POS] <= 1'b1;
			// write one to clear
			run_ctrl_r[ptimer_pkg::AFLAG_POS] <= set_a
				|| (duty_match_flag && !(wr_run && wdata_r[0]));
			run_ctrl_r[ptimer_pkg::PFLAG_POS] <= set_p
				|| (period_match_flag && !(wr_run && wdata_r[1]));
			run_ctrl_r[2] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read channel
	logic [7:0] rd_byte;
	logic rd_hit;
	always_comb
	begin
		rd_hit = (s_axi_araddr[1:0] == 2'b00);
		rd_byte = 8'h00;
		unique case (s_axi_araddr)
			ptimer_pkg::ADDR_MODE_CTRL: rd_byte = mode_ctrl_r;
			ptimer_pkg::ADDR_RUN_CTRL: rd_byte = run_ctrl_r;
			ptimer_pkg::ADDR_COUNT_LOW: rd_byte = count_r[7:0];
			ptimer_pkg::ADDR_COUNT_HIGH: rd_byte = {6'h00, count_r[9:8]};
			ptimer_pkg::ADDR_DUTY_LOW: rd_byte = duty_compare_value[7:0];
			ptimer_pkg::ADDR_DUTY_HIGH:
				rd_byte = {6'h00, duty_compare_value[9:8]};
			ptimer_pkg::ADDR_PERIOD_LOW: rd_byte = period_value_bits[7:0];
			ptimer_pkg::ADDR_PERIOD_HIGH:
				rd_byte = {6'h00, period_value_bits[9:8]};
			default: rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ptimer_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_arready <= 1'b0; // no new address while data is pending
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_hit ? ptimer_pkg::RESP_OKAY
				: ptimer_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	property p_flag_sticky;
		@(posedge aclk) disable iff (!aresetn)
		(duty_match_flag && !(wr_run && wdata_r[0])) |=> duty_match_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("duty flag dropped without clear");
	property p_no_pflag;
		@(posedge aclk) disable iff (!aresetn)
		(clear_source_sel && !pwm_mode && p_match && !period_match_flag)
		|=> !period_match_flag;
	endproperty
	a_no_pflag: assert property (p_no_pflag)
		else $error("period flag set with clear select high");
	property p_on_clear;
		@(posedge aclk) disable iff (!aresetn)
		on_rise |=> (count_r == 10'h000);
	endproperty
	a_on_clear: assert property (p_on_clear)
		else $error("counter not cleared at switch on");
	property p_pause_hold;
		@(posedge aclk) disable iff (!aresetn)
		(counter_pause && !on_rise) |=> $stable(count_r);
	endproperty
	a_pause_hold: assert property (p_pause_hold)
		else $error("counter moved while paused");
	property p_a_clear;
		@(posedge aclk) disable iff (!aresetn)
		(a_match && clear_source_sel && !pwm_mode) |=> (count_r == 10'h000);
	endproperty
	a_a_clear: assert property (p_a_clear)
		else $error("A match did not clear counter");
	property p_init_level;
		@(posedge aclk) disable iff (!aresetn)
		(on_rise && op_mode_sel == ptimer_pkg::MODE_COMPARE)
		|=> ##1 (timer_output_pin == $past(output_init_level ^ output_invert, 2));
	endproperty
	a_init_level: assert property (p_init_level)
		else $error("pin not at initial level after switch on");
	property p_timer_pin;
		@(posedge aclk) disable iff (!aresetn)
		(op_mode_sel == ptimer_pkg::MODE_TIMER) |=> !timer_output_pin;
	endproperty
	a_timer_pin: assert property (p_timer_pin)
		else $error("pin driven in timer mode");
	property p_zero_duty;
		@(posedge aclk) disable iff (!aresetn)
		(duty_compare_value == 10'h000 && !duty_match_flag)
		|=> !duty_match_flag;
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("A flag set with zero duty value");
endmodule

// *** tb/ext_pin_model.sv ***
// model of the pins beyond the timer: external count clock source
`timescale 1ns/1ps
module ext_pin_model
(
	// clock
	input wire logic aclk,
	// pins
	input wire logic timer_output_pin,
	output logic ext_clock_pin
);
	// pin rests low between bursts, no free-running clock
	initial
	begin
		ext_clock_pin = 1'b0;
	end
	// burst of n pulses, each level held four clocks to pass the synchroniser
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++)
		begin
			repeat (4) @(posedge aclk);
			ext_clock_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			ext_clock_pin <= 1'b0;
		end
	endtask
endmodule

// *** tb/periodic_timer_tb_top.sv ***
// self-checking bench for the periodic timer registers and output pin
`timescale 1ns/1ps
module periodic_timer_tb_top;
	logic aclk;
	logic aresetn;
	logic [4:0] awaddr;
	logic [4:0] araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic ext_pin;
	logic pin;
	logic [31:0] v;
	logic [31:0] v1;
	logic [1:0] resp;
	int n_mismatch = 0;
	int cmp_count = 0;

	////////////////////////////////////////////////////////////////////////
	// design and pin partner
	periodic_timer dut
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_clock_pin(ext_pin), .timer_output_pin(pin)
	);
	ext_pin_model partner
	(
		.aclk(aclk), .timer_output_pin(pin), .ext_clock_pin(ext_pin)
	);

	////////////////////////////////////////////////////////////////////////
	// 10 mhz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// compare a register or response value
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// compare the output pin level
	task automatic chk_pin(input logic exp);
		cmp_count++;
		if (pin !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, pin, exp);
		end
	endtask

	// counts and verdict, ends the run
	task automatic give_verdict();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	// read: result left in v
	task automatic rd(input logic [4:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// switch off, clear flags, then program mode and both compare values
	task automatic cfg(input logic [7:0] m, input logic [9:0] du,
		input logic [9:0] pe);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h13);
		wr(ptimer_pkg::ADDR_MODE_CTRL, {24'h0, m});
		wr(ptimer_pkg::ADDR_DUTY_LOW, {24'h0, du[7:0]});
		wr(ptimer_pkg::ADDR_DUTY_HIGH, {30'h0, du[9:8]});
		wr(ptimer_pkg::ADDR_PERIOD_LOW, {24'h0, pe[7:0]});
		wr(ptimer_pkg::ADDR_PERIOD_HIGH, {30'h0, pe[9:8]});
	endtask

	// expected pin: c = mode, function, initial level, invert; late = past A
	function automatic logic pin_exp(input logic [5:0] c, input logic late);
		logic lv;
		case (c[5:4])
			2'b00: lv = (!late || c[3:2] == 2'b00) ? c[1] :
				(c[3:2] == 2'b11) ? !c[1] : c[3];
			2'b10: lv = (c[3:2] == 2'b01 || (c[3:2] == 2'b10 && !late)) ?
				c[1] : !c[1];
			default: return 1'b0;
		endcase
		return lv ^ c[0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		aresetn = 1'b0;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values of every register
		for (int i = 0; i < 8; i++)
		begin
			rd(5'(i * 4));
			chk_reg(v, 32'h0);
		end
		// read/write, read-only and unused upper bits
		wr(ptimer_pkg::ADDR_MODE_CTRL, 32'hf9);
		chk_reg({30'h0, resp}, {30'h0, ptimer_pkg::RESP_OKAY});
		for (int i = 2; i < 8; i++)
			wr(5'(i * 4), 32'hff);
		for (int i = 2; i < 8; i++)
		begin
			rd(5'(i * 4));
			chk_reg(v, i < 4 ? 32'h0 : i % 2 ? 32'h3 : 32'hff);
		end
		rd(ptimer_pkg::ADDR_MODE_CTRL);
		chk_reg(v, 32'hf9);
		// lane 0 strobe low: the write must not land
		wstrb <= 4'he;
		wr(ptimer_pkg::ADDR_DUTY_LOW, 32'h0);
		wstrb <= 4'hf;
		rd(ptimer_pkg::ADDR_DUTY_LOW);
		chk_reg(v, 32'hff);
		// unaligned write refused
		wr(5'h02, 32'h0);
		chk_reg({30'h0, resp}, {30'h0, ptimer_pkg::RESP_SLVERR});
		// unaligned read refused, data zero
		rd(5'h02);
		chk_reg({30'h0, resp}, {30'h0, ptimer_pkg::RESP_SLVERR});
		chk_reg(v, 32'h0);
		// pin over modes, functions, initial levels and inversion
		for (int c = 0; c < 64; c++)
		begin
			if (c[5:4] == 2'b01 || c[5:2] == 4'b1011)
				continue;
			cfg({6'(c), 2'b00}, 10'd40, 10'h200);
			wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
			cyc(5);
			chk_pin(pin_exp(6'(c), 1'b0));
			cyc(80);
			chk_pin(pin_exp(6'(c), 1'b1));
			rd(ptimer_pkg::ADDR_RUN_CTRL);
			chk_reg(v, 32'h19);
		end
		// single pulse: high at switch-on, A match ends pulse and stops
		cfg(8'hb8, 10'd40, 10'h200);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
		cyc(5);
		chk_pin(1'b1);
		cyc(80);
		chk_pin(1'b0);
		rd(ptimer_pkg::ADDR_RUN_CTRL);
		chk_reg(v, 32'h11);
		// clear on A match, no P flag though period is below duty
		cfg(8'h01, 10'd40, 10'd10);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
		cyc(200);
		rd(ptimer_pkg::ADDR_RUN_CTRL);
		chk_reg(v, 32'h19);
		// clear on P match, A never reached, pin left alone
		cfg(8'h30, 10'd40, 10'd10);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
		cyc(200);
		rd(ptimer_pkg::ADDR_RUN_CTRL);
		chk_reg(v, 32'h1a);
		chk_pin(1'b0);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg({31'h0, v <= 32'd10}, 32'h1);
		// zero duty and period: counter wraps past 3ff, no A flag
		cfg(8'hc0, 10'h0, 10'h0);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
		cyc(1100);
		rd(ptimer_pkg::ADDR_COUNT_HIGH);
		chk_reg(v, 32'h0);
		rd(ptimer_pkg::ADDR_RUN_CTRL);
		chk_reg({31'h0, v[0]}, 32'h0);
		// pause holds and resumes, off keeps, switch-on clears
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h98);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		v1 = v;
		cyc(30);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg(v, v1);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
		cyc(20);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg({31'h0, v > v1}, 32'h1);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h10);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		v1 = v;
		cyc(30);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg(v, v1);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h18);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg({31'h0, v < v1}, 32'h1);
		// external clock, rising then falling edges
		cfg(8'h00, 10'h300, 10'h300);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h68);
		partner.pulses(7);
		cyc(10);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg(v, 32'h7);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h70);
		wr(ptimer_pkg::ADDR_RUN_CTRL, 32'h78);
		partner.pulses(5);
		cyc(10);
		rd(ptimer_pkg::ADDR_COUNT_LOW);
		chk_reg(v, 32'h5);
		give_verdict();
	end

	// watchdog, far beyond the expected run length
	initial
	begin
		#3000000;
		n_mismatch++;
		give_verdict();
	end
endmodule
